// >>> design/pin_router_regs.vh
// Purpose: constants of the peripheral pin router
// Assumes: 32-bit Avalon-MM data, 16-bit route registers in the low bits
// Notes:   definitions only
`ifndef PIN_ROUTER_REGS_VH
`define PIN_ROUTER_REGS_VH

// map: group g, register n at byte 0x10*g + 0x4*n
`define PR_MAP_TOP       8'h3f
`define PR_ROUTE_RESET   16'h0000
`define PR_NUM_REGS      16

// field positions, even pin low byte, odd pin high byte
`define PR_SEL_LSB       0
`define PR_CH_LSB        3
`define PR_FN_LSB        5
`define PR_ODD_LSB       8

`define PR_FUNC1         2'h1

`define PR_SEL_NONE      3'h0
`define PR_SEL_I2C       3'h1
`define PR_SEL_SYNC      3'h2
`define PR_SEL_ASYNC     3'h3
`define PR_SEL_TIMER     3'h4

`define PR_FN_NONE       3'h0
`define PR_FN_A          3'h1
`define PR_FN_B          3'h2
`define PR_FN_SCLK       3'h3
`define PR_FN_SEL        3'h4

// slot numbering: 0 none, 1..18 peripheral signals
`define PR_SLOT_I2C      5'h00
`define PR_SLOT_SYNC     5'h02
`define PR_SLOT_ASYNC    5'h0a
`define PR_SLOT_TIMER    5'h0e
`define PR_NSLOT         19
// inactive level of each slot when unrouted: i2c, select_n and uart rx idle high
`define PR_IDLE_LEVELS   19'h0_2c46

`endif

// >>> design/route_regs.v
// Purpose: bank of sixteen route registers with a registered read port
// Assumes: one write or one read per cycle
// Notes:   all words visible in parallel for the router
`timescale 1ns/1ps
`include "pin_router_regs.vh"
module route_regs
(
   input  wire         clk,       // system clock
   input  wire         rst_n,     // synchronised reset, active low
   input  wire         wr_en,     // write strobe
   input  wire         rd_en,     // read strobe
   input  wire         hit,       // address is mapped
   input  wire [3:0]   idx,       // register index
   input  wire [15:0]  wdata,     // write data
   output reg  [15:0]  rdata_r,   // registered read data
   output wire [255:0] all_r      // every register, flat
);
   reg [15:0] mem_r [0:15];
   integer    i;

   genvar g;
   generate
      for (g = 0; g < 16; g = g + 1)
      begin : flat
         assign all_r[16*g+15:16*g] = mem_r[g];
      end
   endgenerate

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         for (i = 0; i < `PR_NUM_REGS; i = i + 1)
            mem_r[i] <= `PR_ROUTE_RESET;
         rdata_r <= 16'h0000;
      end
      else
      begin
         if (wr_en && hit)
            mem_r[idx] <= wdata;
         if (rd_en)
            rdata_r <= hit ? mem_r[idx] : 16'h0000;
      end
   end
endmodule

// >>> design/pin_router.v
// Purpose: routes peripheral signals to port pins under software control
// Assumes: port logic on the same clock; pad inputs asynchronous
// Notes:   pins numbered 8*group + pin; outputs registered, one cycle late
//          reserved selector, channel or function codes act as none
`timescale 1ns/1ps
`include "pin_router_regs.vh"
module pin_router
(
   input  wire         mclk,                // 25 MHz system clock
   input  wire         rst_n,               // asynchronous reset, active low
   input  wire [7:0]   avs_address,         // byte address
   input  wire         avs_read,            // read request
   input  wire         avs_write,           // write request
   input  wire [31:0]  avs_writedata,       // write data
   output wire [31:0]  avs_readdata,        // read data
   output wire         avs_waitrequest,     // stall
   input  wire [63:0]  pin_function_choice, // two bits per pin
   input  wire [31:0]  pin_peripheral_mode, // per pin peripheral enable
   input  wire [31:0]  pad_in,              // pin levels, asynchronous
   output reg  [31:0]  pad_out_r,           // pin drive value
   output reg  [31:0]  pad_oe_r,            // pin drive enable
   input  wire         i2c_scl_out,         // i2c clock drive value
   input  wire         i2c_scl_oe,          // i2c clock drive enable
   output wire         i2c_scl_in,          // i2c clock from pin
   input  wire         i2c_sda_out,         // i2c data drive value
   input  wire         i2c_sda_oe,          // i2c data drive enable
   output wire         i2c_sda_in,          // i2c data from pin
   output wire [1:0]   spi_data_in,         // serial data to unit
   input  wire [1:0]   spi_data_out,        // serial data from unit
   input  wire [1:0]   spi_data_out_oe,     // serial data drive enable
   input  wire [1:0]   spi_serial_clock_out,// serial clock drive value
   input  wire [1:0]   spi_serial_clock_oe, // serial clock drive enable
   output wire [1:0]   spi_serial_clock_in, // serial clock from pin
   input  wire [1:0]   spi_select_n_out,    // select drive value
   input  wire [1:0]   spi_select_n_oe,     // select drive enable
   output wire [1:0]   spi_select_n_in,     // select from pin
   output wire [1:0]   uart_rx_line,        // receive line to unit
   input  wire [1:0]   uart_tx_line,        // transmit line from unit
   input  wire [1:0]   timer_out_zero,      // timer output 0
   input  wire [1:0]   timer_out_zero_oe,   // timer output 0 enable
   output wire [1:0]   timer_capture_zero,  // capture input 0
   input  wire [1:0]   timer_out_one,       // timer output 1
   input  wire [1:0]   timer_out_one_oe,    // timer output 1 enable
   output wire [1:0]   timer_capture_one    // capture input 1
);
   reg          rst_s1_r;
   reg          rst_s2_r;
   reg  [31:0]  pad_s1_r;
   reg  [31:0]  pad_s2_r;
   reg          rd_ack_r;
   reg  [18:0]  slot_in_r;
   reg  [18:0]  slot_in_nxt;
   reg  [18:0]  slot_hit;
   reg  [31:0]  pad_out_nxt;
   reg  [31:0]  pad_oe_nxt;
   reg  [7:0]   fld;
   reg  [4:0]   slot;
   reg          active;
   wire [255:0] route_all;
   wire [15:0]  rdata;
   wire         hit;
   wire [18:0]  slot_out;
   wire [18:0]  slot_oe;
   integer      p;

   // decode selector, channel, function into a slot number, 0 for none
   function [4:0] slot_of;
      input [7:0] f;
      reg   [2:0] sel;
      reg   [1:0] ch;
      reg   [2:0] fn;
      begin
         sel = f[`PR_SEL_LSB+2:`PR_SEL_LSB];
         ch  = f[`PR_CH_LSB+1:`PR_CH_LSB];
         fn  = f[`PR_FN_LSB+2:`PR_FN_LSB];
         slot_of = 5'h00;
         case (sel)
            `PR_SEL_I2C:
               if (ch == 2'h0 && (fn == `PR_FN_A || fn == `PR_FN_B))
                  slot_of = `PR_SLOT_I2C + {2'h0, fn};
            `PR_SEL_SYNC:
               if (!ch[1] && fn >= `PR_FN_A && fn <= `PR_FN_SEL)
                  slot_of = `PR_SLOT_SYNC + {2'h0, ch[0], 2'h0} + {2'h0, fn};
            `PR_SEL_ASYNC:
               if (!ch[1] && (fn == `PR_FN_A || fn == `PR_FN_B))
                  slot_of = `PR_SLOT_ASYNC + {3'h0, ch[0], 1'b0} + {2'h0, fn};
            `PR_SEL_TIMER:
               if (!ch[1] && (fn == `PR_FN_A || fn == `PR_FN_B))
                  slot_of = `PR_SLOT_TIMER + {3'h0, ch[0], 1'b0} + {2'h0, fn};
            default:
               slot_of = 5'h00;
         endcase
      end
   endfunction

   // a pin carries its routed signal only in function 1 with peripheral mode on
   function pin_on;
      input [1:0] choice;
      input       mode;
      begin
         pin_on = (choice == `PR_FUNC1) && mode;
      end
   endfunction

   // reset asserts at once but lets go in step with mclk
   always @(posedge mclk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rst_s1_r <= 1'b0;
         rst_s2_r <= 1'b0;
      end
      else
      begin
         rst_s1_r <= 1'b1;
         rst_s2_r <= rst_s1_r;
      end
   end

   // registers answer reads one cycle late; writes never stall
   assign hit             = (avs_address <= `PR_MAP_TOP) && (avs_address[1:0] == 2'h0);
   assign avs_waitrequest = avs_read && !rd_ack_r;
   assign avs_readdata    = {16'h0000, rdata};

   route_regs u_regs
   (
      .clk     (mclk),
      .rst_n   (rst_s2_r),
      .wr_en   (avs_write),
      .rd_en   (avs_read && !rd_ack_r),
      .hit     (hit),
      .idx     (avs_address[5:2]),
      .wdata   (avs_writedata[15:0]),
      .rdata_r (rdata),
      .all_r   (route_all)
   );

   // slot order: i2c scl,sda; sync ch0 in,out,clk,sel; ch1; uart ch0 rx,tx; ch1; timer
   assign slot_out = {timer_out_one[1], timer_out_zero[1], timer_out_one[0],
                      timer_out_zero[0], uart_tx_line[1], 1'b0, uart_tx_line[0], 1'b0,
                      spi_select_n_out[1], spi_serial_clock_out[1], spi_data_out[1], 1'b0,
                      spi_select_n_out[0], spi_serial_clock_out[0], spi_data_out[0], 1'b0,
                      i2c_sda_out, i2c_scl_out, 1'b0};
   assign slot_oe  = {timer_out_one_oe[1], timer_out_zero_oe[1], timer_out_one_oe[0],
                      timer_out_zero_oe[0], 1'b1, 1'b0, 1'b1, 1'b0,
                      spi_select_n_oe[1], spi_serial_clock_oe[1], spi_data_out_oe[1], 1'b0,
                      spi_select_n_oe[0], spi_serial_clock_oe[0], spi_data_out_oe[0], 1'b0,
                      i2c_sda_oe, i2c_scl_oe, 1'b0};

   always @*
   begin
      fld         = 8'h00;
      slot        = 5'h00;
      active      = 1'b0;
      pad_out_nxt = 32'h0000_0000;
      pad_oe_nxt  = 32'h0000_0000;
      slot_hit    = 19'h0_0000;
      slot_in_nxt = 19'h0_0000;
      for (p = 0; p < 32; p = p + 1)
      begin
         fld    = route_all[p*8 +: 8];
         slot   = slot_of(fld);
         active = pin_on(pin_function_choice[2*p +: 2], pin_peripheral_mode[p]);
         // none or reserved codes leave the pin undriven
         pad_out_nxt[p] = active && slot_out[slot];
         pad_oe_nxt[p]  = active && (slot != 5'h00) && slot_oe[slot];
         // slot_hit marks the inputs that some active pin feeds
         if (active && slot != 5'h00)
         begin
            slot_hit[slot]    = 1'b1;
            slot_in_nxt[slot] = slot_in_nxt[slot] | pad_s2_r[p];
         end
      end
      // two pins on one input would OR together; software must prevent it
      slot_in_nxt = (slot_in_nxt & slot_hit) | (`PR_IDLE_LEVELS & ~slot_hit);
   end

   always @(posedge mclk or negedge rst_s2_r)
   begin
      if (!rst_s2_r)
      begin
         pad_s1_r  <= 32'h0000_0000;
         pad_s2_r  <= 32'h0000_0000;
         rd_ack_r  <= 1'b0;
         pad_out_r <= 32'h0000_0000;
         pad_oe_r  <= 32'h0000_0000;
         slot_in_r <= `PR_IDLE_LEVELS;
      end
      else
      begin
         // only pad_s2_r feeds the router; pad_s1_r may be metastable
         pad_s1_r  <= pad_in;
         pad_s2_r  <= pad_s1_r;
         rd_ack_r  <= avs_read && !rd_ack_r;
         pad_out_r <= pad_out_nxt;
         pad_oe_r  <= pad_oe_nxt;
         slot_in_r <= slot_in_nxt;
      end
   end

   // unit inputs come from flops, so a reroute cannot glitch them
   assign i2c_scl_in          = slot_in_r[1];
   assign i2c_sda_in          = slot_in_r[2];
   assign spi_data_in         = {slot_in_r[7], slot_in_r[3]};
   assign spi_serial_clock_in = {slot_in_r[9], slot_in_r[5]};
   assign spi_select_n_in     = {slot_in_r[10], slot_in_r[6]};
   assign uart_rx_line        = {slot_in_r[13], slot_in_r[11]};
   assign timer_capture_zero  = {slot_in_r[17], slot_in_r[15]};
   assign timer_capture_one   = {slot_in_r[18], slot_in_r[16]};
endmodule

// >>> sim/pin_router_asserts.sv
// Purpose: port-level checks for the pin router
// Assumes: one clock domain, reset active low
// Notes:   pin activity rebuilt from choice and mode inputs
`timescale 1ns/1ps
module pin_router_asserts
(
   input wire        mclk,                // system clock
   input wire        rst_n,               // reset, active low
   input wire        avs_read,            // read request
   input wire        avs_write,           // write request
   input wire [31:0] avs_readdata,        // read data
   input wire        avs_waitrequest,     // stall
   input wire [63:0] pin_function_choice, // two bits per pin
   input wire [31:0] pin_peripheral_mode, // pin enable
   input wire [31:0] pad_in,              // pad levels
   input wire [31:0] pad_oe_r,            // pad drive enable
   input wire        i2c_scl_in,          // i2c clock in
   input wire        i2c_sda_in,          // i2c data in
   input wire [1:0]  spi_select_n_in,     // select in
   input wire [1:0]  uart_rx_line,        // receive in
   input wire [1:0]  spi_data_in,         // serial data in
   input wire [1:0]  spi_serial_clock_in, // serial clock in
   input wire [1:0]  timer_capture_zero,  // capture 0
   input wire [1:0]  timer_capture_one    // capture 1
);
   logic [31:0] act;
   always_comb
      for (int i = 0; i < 32; i++)
         act[i] = pin_function_choice[2*i +: 2] == 2'h1 && pin_peripheral_mode[i];
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   func_one_only_a: assert property ((pad_oe_r & ~$past(act)) == 32'h0000_0000)
      else $error("pad driven on a pin outside function 1");
   idle_inputs_a: assert property ((act == 32'h0000_0000) [*2] |->
      {i2c_scl_in, i2c_sda_in, spi_select_n_in, uart_rx_line, spi_data_in,
      spi_serial_clock_in, timer_capture_zero, timer_capture_one} == 14'h3f00)
      else $error("unit inputs not idle with no pin active");
   rx_from_pad_a: assert property (
      !uart_rx_line[1] |-> $past(|act) && $past(~&pad_in, 3))
      else $error("receive line low without a low active pad");
   wait_only_read_a: assert property (avs_waitrequest |-> avs_read)
      else $error("stall without a read");
   write_nostall_a: assert property (avs_write |-> !avs_waitrequest)
      else $error("write stalled");
   read_onewait_a: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read not answered after one wait cycle");
   read_after_wait_a: assert property (avs_read && !avs_waitrequest |-> $past(avs_waitrequest))
      else $error("read answered with no wait cycle");
   rdata_hold_a: assert property (!(avs_read && avs_waitrequest) |=> $stable(avs_readdata))
      else $error("read data moved without a read");
   rdata_upper_a: assert property (avs_readdata[31:16] == 16'h0000)
      else $error("read data upper half not zero");
endmodule
bind pin_router pin_router_asserts chk_i (.mclk, .rst_n, .avs_read, .avs_write, .avs_readdata,
   .avs_waitrequest, .pin_function_choice, .pin_peripheral_mode, .pad_in, .pad_oe_r,
   .i2c_scl_in, .i2c_sda_in, .spi_select_n_in, .uart_rx_line, .spi_data_in,
   .spi_serial_clock_in, .timer_capture_zero, .timer_capture_one);

// >>> sim/pad_model.sv
// Purpose: port pin stand-in for the router bench
// Assumes: pad follows the router when enabled, else the outside level
// Notes:   no pulls modelled; ext_level must always be driven
`timescale 1ns/1ps
module pad_model
(
   input  wire [31:0] pad_out_r, // router drive value
   input  wire [31:0] pad_oe_r,  // router drive enable
   input  wire [31:0] ext_level, // outside level per pad
   output wire [31:0] pad_in     // level seen at the pad
);
   assign pad_in = (pad_oe_r & pad_out_r) | (~pad_oe_r & ext_level);
endmodule

// >>> sim/pin_router_tb.sv
// Purpose: self-checking bench for the pin router
// Assumes: 25 MHz clock; every transfer waits for waitrequest low
// Notes:   software order of disable, route, enable kept by the bench
`timescale 1ns/1ps
module pin_router_tb;
   logic        mclk = 0, rst_n = 0, avs_read = 0, avs_write = 0, drv = 1, en = 1;
   logic [7:0]  avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0000_0000, ext_level = 32'hffff_ffff;
   logic [31:0] pin_peripheral_mode = 32'h0000_0000;
   logic [63:0] pin_function_choice = 64'h0000_0000_0000_0000;
   logic [15:0] regs [16] = '{default: 16'h0000};
   logic [7:0]  tbl [15] = '{8'h21, 8'h41, 8'h29, 8'h2a, 8'h4a, 8'h62, 8'h8a, 8'ha2,
                            8'h43, 8'h2b, 8'h2c, 8'h44, 8'h34, 8'h25, 8'h00};
   logic [14:0] flags = 15'h0d73;
   int          n_tests = 0, miscompares = 0;
   wire [31:0]  avs_readdata, pad_out_r, pad_oe_r, pad_in;
   wire         avs_waitrequest, i2c_scl_in, i2c_sda_in;
   wire [1:0]   spi_data_in, spi_serial_clock_in, spi_select_n_in, uart_rx_line;
   wire [1:0]   timer_capture_zero, timer_capture_one;
   wire [1:0]   d2 = {2{drv}}, e2 = {2{en}};
   always #20 mclk = ~mclk;
   pin_router uut
   (
      .mclk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
      .avs_waitrequest, .pin_function_choice, .pin_peripheral_mode, .pad_in, .pad_out_r,
      .pad_oe_r, .i2c_scl_out(drv), .i2c_scl_oe(en), .i2c_scl_in, .i2c_sda_out(drv),
      .i2c_sda_oe(en), .i2c_sda_in, .spi_data_in, .spi_data_out(d2), .spi_data_out_oe(e2),
      .spi_serial_clock_out(d2), .spi_serial_clock_oe(e2), .spi_serial_clock_in,
      .spi_select_n_out(d2), .spi_select_n_oe(e2), .spi_select_n_in, .uart_rx_line,
      .uart_tx_line(d2), .timer_out_zero(d2), .timer_out_zero_oe(e2), .timer_capture_zero,
      .timer_out_one(d2), .timer_out_one_oe(e2), .timer_capture_one
   );
   pad_model pads (.pad_out_r, .pad_oe_r, .ext_level, .pad_in);
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      output logic [31:0] q);
      @(posedge mclk);
      avs_address <= a;
      avs_writedata <= {16'h0000, d};
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge mclk);
      // waitrequest and readdata are taken at the edge, before it updates them
      while (avs_waitrequest !== 1'b0)
         @(posedge mclk);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (wr && a < 8'h40 && a[1:0] == 2'b00)
         regs[a[5:2]] = d;
   endtask
   task automatic rd(input logic [7:0] a);
      logic [31:0] q;
      bus(1'b0, a, 16'h0000, q);
      chk("readdata", (a < 8'h40 && a[1:0] == 2'b00) ? {16'h0000, regs[a[5:2]]} : 0, q);
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (5000) @(posedge mclk);
      miscompares++;
      summarize();
   end
   initial
   begin
      logic [31:0] q;
      logic [4:0]  p;
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      settle(2);
      chk("idle inputs", 32'h0000_3f00, 32'({i2c_scl_in, i2c_sda_in, spi_select_n_in,
          uart_rx_line, spi_data_in, spi_serial_clock_in, timer_capture_zero,
          timer_capture_one}));
      for (int i = 0; i < 16; i++)
         rd({2'b00, i[3:0], 2'b00});
      $display("test reset done");
      for (int i = 0; i < 15; i++)
      begin
         p = 5'(2 * i + i % 2);
         bus(1'b1, {2'b00, p[4:1], 2'b00},
             p[0] ? {tbl[i], 8'h00} : {8'h00, tbl[i]}, q);
      end
      bus(1'b1, 8'h3c, 16'h2c2c, q);
      @(posedge mclk);
      pin_function_choice <= 64'h5555_5555_5555_5555;
      @(posedge mclk);
      pin_peripheral_mode <= 32'hffff_ffff;
      settle(2);
      for (int i = 0; i < 15; i++)
      begin
         p = 5'(2 * i + i % 2);
         chk("pin drive", 32'({2{flags[i]}}),
             32'({pad_oe_r[p], pad_out_r[p] & pad_oe_r[p]}));
      end
      @(posedge mclk);
      drv <= 1'b0;
      settle(1);
      chk("twin pins", 32'h0000_000c, 32'({pad_oe_r[31:30], pad_out_r[31:30]}));
      @(posedge mclk);
      en <= 1'b0;
      settle(1);
      chk("unit enables", 32'h0000_0001, 32'({pad_oe_r[31:30], pad_oe_r[16]}));
      $display("test routing done");
      @(posedge mclk);
      drv <= 1'b1;
      en <= 1'b1;
      ext_level <= 32'hfff7_ff7f;
      settle(3);
      chk("routed inputs", 32'h0000_0000, 32'({uart_rx_line[1], spi_data_in[1]}));
      @(posedge mclk);
      pin_function_choice[1:0] <= 2'h2;
      pin_peripheral_mode[8] <= 1'b0;
      settle(1);
      chk("disabled pins", 32'h0000_0000, 32'({pad_oe_r[0], pad_oe_r[8]}));
      $display("test inputs done");
      bus(1'b1, 8'h41, 16'hffff, q);
      for (int i = 0; i < 17; i++)
         rd(8'(4 * i));
      $display("test registers done");
      summarize();
   end
endmodule
